/* File: src/rtc_core.v */
// Purpose: Timekeeping core: divider, time copies, alarm, flags, bus.
// Assumes: All inputs synchronous to clock; bus strobes sampled per cycle.
// Notes:   Time base ticks come from a fractional accumulator on clock.
`timescale 1ns/1ps
`include "rtc_core_regs.vh"

module rtc_core #(
  parameter integer CLK_HZ    = `RTC_CLK_HZ,
  parameter integer OSC_HZ    = `RTC_OSC_HZ,
  parameter integer PRE_TICKS = `RTC_PRE_TICKS,
  parameter integer UPD_TICKS = `RTC_UPD_TICKS
) (
  // Clock and reset
  input  wire       clock,
  input  wire       rst,
  // Multiplexed host bus
  input  wire [7:0] adIn,
  output wire [7:0] adOut,
  output wire       adOe,
  input  wire       addrLatchStrobe,
  input  wire       chipSelN,
  input  wire       dataStrobeN,
  input  wire       readWriteN,
  // Open-drain interrupt, drives low while adOe-style enable is high
  output wire       intReqOut,
  output wire       intReqOe,
  // Square wave
  output wire       squareOutPin
);

  // Time base and divider chain.
  reg  [25:0] phaseAcc_ff;
  reg         oscTick_ff;
  reg  [14:0] div_ff;
  wire [26:0] phaseSum;
  wire        divRun;
  wire        updateEnd;
  wire        inPending;

  // Registers.
  reg  [79:0] localTime_ff;
  reg  [79:0] userTime_ff;
  reg         loadPending_ff;
  reg  [6:0]  ctrlA_ff;
  reg  [7:0]  ctrlB_ff;
  reg         updPending_ff;
  reg         periodicFlag_ff;
  reg         alarmFlag_ff;
  reg         updateFlag_ff;
  reg         summaryFlag_ff;
  reg  [7:0]  addrLat_ff;
  reg  [7:0]  adOut_ff;
  reg         asPrev_ff;
  reg         wrPrev_ff;
  reg         rdPrev_ff;
  reg         tapPrev_ff;
  reg         square_ff;

  wire        freeze = ctrlB_ff[`RTC_B_FREEZE];
  wire        fmtBin = ctrlB_ff[`RTC_B_DF];
  wire        hour12 = ~ctrlB_ff[`RTC_B_HF];

  // Time base: 32768 ticks per second out of the system clock.
  assign phaseSum = {1'b0, phaseAcc_ff} + OSC_HZ[26:0];

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      phaseAcc_ff <= 26'h0000000;
      oscTick_ff  <= 1'b0;
    end else if (phaseSum >= CLK_HZ[26:0]) begin
      phaseAcc_ff <= phaseSum[25:0] - CLK_HZ[25:0];
      oscTick_ff  <= 1'b1;
    end else begin
      phaseAcc_ff <= phaseSum[25:0];
      oscTick_ff  <= 1'b0;
    end
  end

  // Held divider restarts half-way, so the first update lands 500 ms on.
  assign divRun = (ctrlA_ff[6:4] == `RTC_OSC_RUN);

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      div_ff <= `RTC_DIV_START;
    end else if (!divRun) begin
      div_ff <= `RTC_DIV_START;
    end else if (oscTick_ff) begin
      div_ff <= div_ff + 15'h0001;
    end
  end

  // Update cycle occupies the first UPD_TICKS of each period.
  assign updateEnd = divRun & oscTick_ff &
                     (div_ff == UPD_TICKS[14:0] - 15'h0001);
  assign inPending = (div_ff >= 15'h7FFF - PRE_TICKS[14:0] + 15'h0001) |
                     (div_ff < UPD_TICKS[14:0]);

  // Tap select: code 1,2 alias 8,9; code n picks div bit n-2.
  reg  [3:0] tapIdx;
  wire [3:0] rate = ctrlA_ff[3:0];
  wire       tapNow;

  always @* begin
    case (rate)
      4'h1: tapIdx = 4'h6;
      4'h2: tapIdx = 4'h7;
      default: tapIdx = rate - 4'h2;
    endcase
  end

  assign tapNow = (rate != 4'h0) & div_ff[tapIdx];

  // Format helpers.
  function [6:0] toBin;
    input [7:0] v;
    input       bin;
    begin
      toBin = bin ? v[6:0] : ({3'h0, v[7:4]} * 7'h0A + {3'h0, v[3:0]});
    end
  endfunction

  function [7:0] toFmt;
    input [6:0] n;
    input       bin;
    reg   [6:0] t;
    reg   [6:0] u;
    begin
      t = n / 7'h0A;
      u = n - t * 7'h0A;
      toFmt = bin ? {1'b0, n} : {t[3:0], u[3:0]};
    end
  endfunction

  // Advance one second from the selected source copy.
  reg  [79:0] srcTime;
  reg  [79:0] newTime;
  reg  [6:0]  sec, mnt, hr, wd, md, mo, yr, dim;
  reg  [6:0]  nSec, nMin, nHr, nWd, nMd, nMo, nYr;
  reg  [7:0]  hourFmt;
  reg         pm, nPm, cMin, cHr, cDay, cMo;
  reg         alarmHit;

  always @* begin
    srcTime = loadPending_ff ? userTime_ff : localTime_ff;
    sec  = toBin(srcTime[7:0], fmtBin);
    mnt  = toBin(srcTime[23:16], fmtBin);
    pm   = hour12 & srcTime[39];
    hr   = toBin({1'b0, srcTime[38:32]}, fmtBin);
    wd   = toBin(srcTime[55:48], fmtBin);
    md   = toBin(srcTime[63:56], fmtBin);
    mo   = toBin(srcTime[71:64], fmtBin);
    yr   = toBin(srcTime[79:72], fmtBin);
    cMin = (sec == 7'h3B);
    nSec = cMin ? 7'h00 : sec + 7'h01;
    cHr  = cMin & (mnt == 7'h3B);
    nMin = cMin ? ((mnt == 7'h3B) ? 7'h00 : mnt + 7'h01) : mnt;
    nHr  = hr;
    nPm  = pm;
    cDay = 1'b0;
    if (cHr) begin
      if (hour12) begin
        if (hr == 7'h0C) begin
          nHr = 7'h01;
        end else begin
          nHr = hr + 7'h01;
          if (hr == 7'h0B) begin
            nPm  = ~pm;
            cDay = pm;
          end
        end
      end else begin
        cDay = (hr == 7'h17);
        nHr  = cDay ? 7'h00 : hr + 7'h01;
      end
    end
    case (mo)
      7'h02: dim = (yr[1:0] == 2'h0) ? 7'h1D : 7'h1C;
      7'h04, 7'h06, 7'h09, 7'h0B: dim = 7'h1E;
      default: dim = 7'h1F;
    endcase
    nWd = cDay ? ((wd == 7'h07) ? 7'h01 : wd + 7'h01) : wd;
    cMo = cDay & (md == dim);
    nMd = cDay ? (cMo ? 7'h01 : md + 7'h01) : md;
    nMo = cMo ? ((mo == 7'h0C) ? 7'h01 : mo + 7'h01) : mo;
    nYr = (cMo & (mo == 7'h0C)) ?
          ((yr == 7'h63) ? 7'h00 : yr + 7'h01) : yr;
    hourFmt = toFmt(nHr, fmtBin);
    newTime = {toFmt(nYr, fmtBin), toFmt(nMo, fmtBin),
               toFmt(nMd, fmtBin), toFmt(nWd, fmtBin),
               srcTime[47:40], hour12 & nPm, hourFmt[6:0],
               srcTime[31:24], toFmt(nMin, fmtBin),
               srcTime[15:8], toFmt(nSec, fmtBin)};
    // Hour compare uses the whole byte, PM bit included.
    alarmHit = ((srcTime[15:14] == 2'h3) |
                (srcTime[15:8] == newTime[7:0])) &
               ((srcTime[31:30] == 2'h3) |
                (srcTime[31:24] == newTime[23:16])) &
               ((srcTime[47:46] == 2'h3) |
                (srcTime[47:40] == newTime[39:32]));
  end

  // Host bus strobes, sampled each cycle.
  wire asFall  = asPrev_ff & ~addrLatchStrobe;
  wire wrRise  = ~wrPrev_ff & readWriteN & ~chipSelN;
  wire rdRise  = ~rdPrev_ff & dataStrobeN & ~chipSelN;
  wire hostWr  = wrRise;
  wire timeSel = (addrLat_ff < `RTC_TIME_BYTES);
  wire flagRd  = rdRise & (addrLat_ff == `RTC_OFS_FLAGS);

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      asPrev_ff  <= 1'b0;
      wrPrev_ff  <= 1'b1;
      rdPrev_ff  <= 1'b1;
      addrLat_ff <= 8'h00;
    end else begin
      asPrev_ff <= addrLatchStrobe;
      wrPrev_ff <= readWriteN;
      rdPrev_ff <= dataStrobeN;
      if (asFall) begin
        addrLat_ff <= adIn;
      end
    end
  end

  // Time copies and control registers.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      localTime_ff   <= 80'h00_01_01_01_00_00_00_00_00_00;
      userTime_ff    <= 80'h00_01_01_01_00_00_00_00_00_00;
      loadPending_ff <= 1'b0;
      ctrlA_ff       <= `RTC_A_RESET;
      ctrlB_ff       <= `RTC_B_RESET;
    end else begin
      if (updateEnd) begin
        localTime_ff <= newTime;
        if (!freeze) begin
          userTime_ff    <= newTime;
          loadPending_ff <= 1'b0;
        end
      end
      if (hostWr) begin
        if (timeSel) begin
          userTime_ff[{addrLat_ff[3:0], 3'h0} +: 8] <= adIn;
          // While frozen only the buffer moves; the local copy takes the
          // buffer, one second on, at the next update even while frozen.
          if (freeze) begin
            loadPending_ff <= 1'b1;
          end else begin
            localTime_ff[{addrLat_ff[3:0], 3'h0} +: 8] <= adIn;
          end
        end else if (addrLat_ff == `RTC_OFS_CTRL_A) begin
          ctrlA_ff <= adIn[6:0];
        end else if (addrLat_ff == `RTC_OFS_CTRL_B) begin
          ctrlB_ff <= adIn;
        end
      end
    end
  end

  // Events and flags; a same-cycle event beats the read clear.
  wire periodicEvt = tapNow & ~tapPrev_ff;
  wire perReq = periodicEvt & ctrlB_ff[`RTC_B_PIE];
  wire almReq = updateEnd & alarmHit & ctrlB_ff[`RTC_B_AIE];
  wire updReq = updateEnd & ctrlB_ff[`RTC_B_UIE] & ~freeze;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tapPrev_ff      <= 1'b0;
      updPending_ff   <= 1'b0;
      periodicFlag_ff <= 1'b0;
      alarmFlag_ff    <= 1'b0;
      updateFlag_ff   <= 1'b0;
      summaryFlag_ff  <= 1'b0;
    end else begin
      tapPrev_ff    <= tapNow;
      updPending_ff <= divRun & inPending & ~updateEnd & ~freeze;
      periodicFlag_ff <= periodicEvt |
                         (periodicFlag_ff & ~flagRd);
      alarmFlag_ff    <= (updateEnd & alarmHit) |
                         (alarmFlag_ff & ~flagRd);
      updateFlag_ff   <= updateEnd |
                         (updateFlag_ff & ~flagRd);
      summaryFlag_ff  <= perReq | almReq | updReq |
                         (summaryFlag_ff & ~flagRd);
    end
  end

  // The square wave follows the tap only while enabled; low otherwise.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      square_ff <= 1'b0;
    end else begin
      square_ff <= tapNow & ctrlB_ff[`RTC_B_SQUARE_OUT_ENABLE];
    end
  end

  assign squareOutPin = square_ff;

  // Interrupt pin follows enabled flags, so a flag read releases it.
  assign intReqOe = (periodicFlag_ff & ctrlB_ff[`RTC_B_PIE]) |
                    (alarmFlag_ff & ctrlB_ff[`RTC_B_AIE]) |
                    (updateFlag_ff & ctrlB_ff[`RTC_B_UIE] &
                     ~freeze);
  assign intReqOut = 1'b0;

  // Read data, registered one cycle behind the latched address.
  reg [7:0] rdData;

  always @* begin
    if (timeSel) begin
      rdData = userTime_ff[{addrLat_ff[3:0], 3'h0} +: 8];
    end else begin
      case (addrLat_ff)
        `RTC_OFS_CTRL_A:   rdData = {updPending_ff, ctrlA_ff};
        `RTC_OFS_CTRL_B:   rdData = ctrlB_ff;
        `RTC_OFS_FLAGS:    rdData = {summaryFlag_ff, periodicFlag_ff,
                                     alarmFlag_ff, updateFlag_ff, 4'h0};
        `RTC_OFS_STATUS_D: rdData = `RTC_STATUS_D_VAL;
        default:           rdData = 8'h00;
      endcase
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      adOut_ff <= 8'h00;
    end else begin
      adOut_ff <= rdData;
    end
  end

  assign adOut = adOut_ff;
  assign adOe  = ~chipSelN & ~dataStrobeN & readWriteN;

endmodule // rtc_core

/* File: src/rtc_core_regs.vh */
// Purpose: Register map, field positions and timing counts of the RTC core.
// Assumes: Byte-wide registers on a multiplexed address/data bus.
// Notes:   Overview of the rules follows.
`ifndef RTC_CORE_REGS_VH
`define RTC_CORE_REGS_VH

`define RTC_OFS_SECONDS_COUNT  8'h00
`define RTC_OFS_SECONDS_ALARM  8'h01
`define RTC_OFS_MINUTES_COUNT  8'h02
`define RTC_OFS_MINUTES_ALARM  8'h03
`define RTC_OFS_HOURS_COUNT    8'h04
`define RTC_OFS_HOURS_ALARM    8'h05
`define RTC_OFS_WEEKDAY_COUNT  8'h06
`define RTC_OFS_MONTHDAY_COUNT 8'h07
`define RTC_OFS_MONTH_COUNT    8'h08
`define RTC_OFS_YEAR_COUNT     8'h09
`define RTC_OFS_CTRL_A         8'h0A
`define RTC_OFS_CTRL_B         8'h0B
`define RTC_OFS_FLAGS          8'h0C
`define RTC_OFS_STATUS_D       8'h0D
`define RTC_TIME_BYTES         10

// Control B field positions.
`define RTC_B_FREEZE  7
`define RTC_B_PIE     6
`define RTC_B_AIE     5
`define RTC_B_UIE     4
`define RTC_B_SQUARE_OUT_ENABLE    3
`define RTC_B_DF      2
`define RTC_B_HF      1
`define RTC_B_DSE     0

`define RTC_A_RESET       7'h20
`define RTC_B_RESET       8'h00
`define RTC_OSC_RUN       3'h2
`define RTC_STATUS_D_VAL  8'h80

// Timing, in time-base ticks unless marked.
`define RTC_CLK_HZ        40000000
`define RTC_OSC_HZ        32768
`define RTC_DIV_START     15'h4000
`define RTC_PRE_US        244
`define RTC_PRE_TICKS     ((`RTC_PRE_US * `RTC_OSC_HZ + 999999) / 1000000)
`define RTC_UPD_US        1984
`define RTC_UPD_TICKS     ((`RTC_UPD_US * `RTC_OSC_HZ + 999999) / 1000000)

`endif

/* File: bench/rtc_core_asserts.sv */
// Purpose: Port-level checks of the RTC core.
// Assumes: Shadows track the latched address and control bytes on the bus.
// Notes:   Period checks hold only with two clocks per time-base tick.
`timescale 1ns/1ps
module rtc_core_asserts #(
  parameter integer CLK_HZ = 40000000,
  parameter integer OSC_HZ = 32768
) (
  // Clock and reset
  input wire       clock,
  input wire       rst,
  // Host bus
  input wire [7:0] adIn,
  input wire [7:0] adOut,
  input wire       adOe,
  input wire       addrLatchStrobe,
  input wire       chipSelN,
  input wire       dataStrobeN,
  input wire       readWriteN,
  // Request and square outputs
  input wire       intReqOut,
  input wire       intReqOe,
  input wire       squareOutPin
);
  localparam bit FAST = CLK_HZ == 2 * OSC_HZ;
  logic [7:0] addr_ff;
  logic [7:0] ctrlA_ff;
  logic [7:0] ctrlB_ff;
  logic       strobe_ff;
  logic       rw_ff;
  wire        wrDone = !rw_ff && readWriteN && !chipSelN;
  wire        flagRd = !chipSelN && addr_ff == 8'h0C;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      strobe_ff <= 1'b0;
      rw_ff     <= 1'b1;
      addr_ff   <= 8'h00;
      ctrlA_ff  <= 8'h20;
      ctrlB_ff  <= 8'h00;
    end else begin
      strobe_ff <= addrLatchStrobe;
      rw_ff     <= readWriteN;
      if (strobe_ff && !addrLatchStrobe)
        addr_ff <= adIn;
      if (wrDone && addr_ff == 8'h0A)
        ctrlA_ff <= adIn;
      if (wrDone && addr_ff == 8'h0B)
        ctrlB_ff <= adIn;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence rdLive;
    adOe ##1 adOe;
  endsequence
  sequence sqIdle;
    (!ctrlB_ff[3] || ctrlA_ff[3:0] == 4'h0) [*3];
  endsequence
  reset_quiet_a:
    assert property ($fell(rst) |-> adOut == 8'h00 && !intReqOe)
    else $error("outputs busy after reset");
  flag_release_a:
    assert property ($rose(dataStrobeN) && flagRd && !ctrlB_ff[6]
      |=> !intReqOe) else $error("request kept after flag read");
  no_enable_a:
    assert property (ctrlB_ff[6:4] == 3'b000 |-> !intReqOe)
    else $error("request without enable");
  freeze_mask_a:
    assert property (ctrlB_ff[7] && ctrlB_ff[6:5] == 2'b00 |-> !intReqOe)
    else $error("update request while frozen");
  int_low_a:
    assert property (intReqOe |-> intReqOut == 1'b0)
    else $error("request line not pulled low");
  pending_frozen_a:
    assert property ((ctrlB_ff[7] && $past(ctrlB_ff[7]) && addr_ff == 8'h0A)
      ##0 rdLive |-> !adOut[7]) else $error("pending bit set while frozen");
  square_off_a:
    assert property (sqIdle |-> !squareOutPin)
    else $error("square output moves while off");
  square_half_a:
    assert property (FAST && $rose(squareOutPin) && ctrlB_ff[3]
      && ctrlA_ff[3:0] == 4'h3 && $past(ctrlA_ff[3:0], 2) == 4'h3
      |-> ##4 ($fell(squareOutPin) || ctrlA_ff[3:0] != 4'h3
               || !ctrlB_ff[3]))
    else $error("square half period wrong");
  period_req_a:
    assert property (FAST && $rose(dataStrobeN) && flagRd
      && ctrlB_ff[6:4] == 3'b100 && ctrlA_ff[3:0] == 4'h3
      |-> ##[1:10] intReqOe) else $error("periodic request missing");
endmodule // rtc_core_asserts

/* File: bench/rtc_host_bus.sv */
// Purpose: Host processor model on the multiplexed address/data bus.
// Assumes: Signals change only just after a rising clock edge.
// Notes:   A released data bus shows the inverse of its last value.
`timescale 1ns/1ps
module rtc_host_bus (
  // Clock
  input  wire        clock,
  // Bus toward the core
  input  wire  [7:0] adOut,
  output logic [7:0] adIn,
  output logic       addrLatchStrobe,
  output logic       chipSelN,
  output logic       dataStrobeN,
  output logic       readWriteN
);
  initial begin
    adIn            = 8'h00;
    addrLatchStrobe = 1'b0;
    chipSelN        = 1'b1;
    dataStrobeN     = 1'b1;
    readWriteN      = 1'b1;
  end
  task automatic phase(input logic [7:0] a);
    @(posedge clock);
    addrLatchStrobe <= 1'b1;
    adIn            <= a;
    @(posedge clock);
    addrLatchStrobe <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    phase(a);
    chipSelN   <= 1'b0;
    readWriteN <= 1'b0;
    adIn       <= d;
    repeat (2) @(posedge clock);
    readWriteN <= 1'b1;
    @(posedge clock);
    chipSelN   <= 1'b1;
    adIn       <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    phase(a);
    chipSelN    <= 1'b0;
    dataStrobeN <= 1'b0;
    adIn        <= ~a;
    repeat (3) @(posedge clock);
    d = adOut;
    dataStrobeN <= 1'b1;
    @(posedge clock);
    chipSelN    <= 1'b1;
  endtask
endmodule // rtc_host_bus

/* File: bench/rtc_core_test.sv */
// Purpose: Self-checking bench for the RTC core.
// Assumes: Two clocks per time-base tick keep the first update short.
// Notes:   Rollovers run once in 24-hour binary, once in 12-hour BCD.
`timescale 1ns/1ps
module rtc_core_test;
  localparam integer CLK_HZ = 65536;
  localparam integer OSC_HZ = 32768;
  logic       clock;
  logic       rst;
  wire  [7:0] adIn;
  wire  [7:0] adOut;
  wire        adOe, addrLatchStrobe, chipSelN, dataStrobeN, readWriteN;
  wire        intReqOut, intReqOe, squareOutPin;
  wire        intLineN;
  int         error_cnt;
  int         n_tests;
  int         rise;
  logic [7:0] rdVal;
  // Row: address, byte written, byte expected back.
  logic [23:0] rows [16] = '{24'h0B8686, 24'h0AA020, 24'h003B3B,
    24'h01C0C0, 24'h023B3B, 24'h03C0C0, 24'h041717, 24'h05C0C0,
    24'h060707, 24'h071F1F, 24'h080C0C, 24'h096363, 24'h0CFF00,
    24'h0D0080, 24'h0E5500, 24'h0B3636};
  logic [7:0]  wrapped [10] = '{8'h00, 8'hC0, 8'h00, 8'hC0, 8'h00,
    8'hC0, 8'h01, 8'h01, 8'h01, 8'h00};
  // Byte written (upper) and byte expected after the update (lower).
  logic [15:0] leap [10] = '{16'h5900, 16'h0000, 16'h5900, 16'h0000,
    16'h9112, 16'h1212, 16'h0701, 16'h2829, 16'h0202, 16'h0404};
  // The request line has a pull-up on the board.
  assign intLineN = intReqOe ? intReqOut : 1'b1;
  rtc_core #(.CLK_HZ(CLK_HZ), .OSC_HZ(OSC_HZ)) i_dut (
    .clock(clock), .rst(rst), .adIn(adIn), .adOut(adOut), .adOe(adOe),
    .addrLatchStrobe(addrLatchStrobe), .chipSelN(chipSelN),
    .dataStrobeN(dataStrobeN), .readWriteN(readWriteN),
    .intReqOut(intReqOut), .intReqOe(intReqOe),
    .squareOutPin(squareOutPin));
  rtc_host_bus i_host (
    .clock(clock), .adOut(adOut), .adIn(adIn),
    .addrLatchStrobe(addrLatchStrobe), .chipSelN(chipSelN),
    .dataStrobeN(dataStrobeN), .readWriteN(readWriteN));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic countRises(output int c);
    logic p;
    c = 0;
    p = squareOutPin;
    repeat (512) begin
      @(posedge clock);
      if (squareOutPin && !p)
        c++;
      p = squareOutPin;
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Each of the two update waits is near 33000 clocks; the rest is short.
  initial begin
    repeat (90000) @(posedge clock);
    error_cnt++;
    complete_run();
  end
  initial begin
    error_cnt = 0;
    n_tests   = 0;
    rst       = 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      i_host.wr(rows[i][23:16], rows[i][15:8]);
      i_host.rd(rows[i][23:16], rdVal);
      chk(rdVal, rows[i][7:0]);
    end
    $display("register rows done");
    for (int k = 0; k < 40000 && intLineN !== 1'b0; k++)
      @(posedge clock);
    chk({7'h00, intLineN}, 8'h00);
    i_host.rd(8'h0C, rdVal);
    chk(rdVal, 8'hB0);
    // The clear lands on the edge that ends the read; look after it.
    @(negedge clock);
    chk({7'h00, intLineN}, 8'h01);
    for (int i = 0; i < 10; i++) begin
      i_host.rd(8'(i), rdVal);
      chk(rdVal, wrapped[i]);
    end
    $display("update rollover done");
    i_host.wr(8'h0B, 8'h08);
    for (int n = 0; n < 10; n++) begin
      i_host.wr(8'h0A, 8'h20 | 8'(n));
      repeat (64) @(posedge clock);
      countRises(rise);
      chk(8'(rise), n == 0 ? 8'h00 : 8'(512 >> (n < 3 ? n + 7 : n)));
    end
    $display("rate sweep done");
    i_host.wr(8'h0A, 8'h23);
    i_host.wr(8'h0B, 8'h48);
    i_host.rd(8'h0C, rdVal);
    // Leave a full tap period so a periodic event always lands.
    repeat (10) @(posedge clock);
    i_host.rd(8'h0C, rdVal);
    chk(rdVal & 8'hC0, 8'hC0);
    repeat (10) @(posedge clock);
    i_host.wr(8'h0B, 8'h00);
    @(negedge clock);
    chk({7'h00, intLineN}, 8'h01);
    countRises(rise);
    chk(8'(rise), 8'h00);
    $display("periodic and enable tests done");
    // Twelve-hour BCD: 11:59:59 PM on 28 February of a leap year.
    i_host.wr(8'h0A, 8'h70);
    i_host.rd(8'h0C, rdVal);
    i_host.wr(8'h0B, 8'h80);
    for (int i = 0; i < 10; i++)
      i_host.wr(8'(i), leap[i][15:8]);
    i_host.wr(8'h0B, 8'h20);
    i_host.wr(8'h0A, 8'h20);
    for (int k = 0; k < 40000 && intLineN !== 1'b0; k++)
      @(posedge clock);
    i_host.rd(8'h0C, rdVal);
    chk(rdVal, 8'hB0);
    for (int i = 0; i < 10; i++) begin
      i_host.rd(8'(i), rdVal);
      chk(rdVal, leap[i][7:0]);
    end
    $display("twelve-hour leap test done");
    complete_run();
  end
endmodule // rtc_core_test
bind rtc_core rtc_core_asserts #(.CLK_HZ(CLK_HZ), .OSC_HZ(OSC_HZ)) i_chk (
  .clock(clock), .rst(rst), .adIn(adIn), .adOut(adOut), .adOe(adOe),
  .addrLatchStrobe(addrLatchStrobe), .chipSelN(chipSelN),
  .dataStrobeN(dataStrobeN), .readWriteN(readWriteN),
  .intReqOut(intReqOut), .intReqOe(intReqOe), .squareOutPin(squareOutPin));
